// ---- scddp_pkg.sv ----
// constants shared by the serial clock divider and data port
package scddp_pkg;

    // ==========================================================
    // register addresses and reset values
    localparam logic [7:0] SCDDP_ADDR_DATA  = 8'h9B;
    localparam logic [7:0] SCDDP_ADDR_DIV   = 8'h9D;
    localparam logic [7:0] SCDDP_RST_DATA   = 8'h00;
    localparam logic [7:0] SCDDP_RST_DIV    = 8'h00;

    // ==========================================================
    // frame and divider figures
    localparam int         SCDDP_FRAME_BITS = 8;
    localparam logic [2:0] SCDDP_LAST_BIT   = 3'h7;
    localparam logic [8:0] SCDDP_DIV_MAX    = 9'h0FF;

    // ==========================================================
    // transfer states, one-hot
    typedef enum logic [2:0] {
        SCDDP_IDLE = 3'b001,
        SCDDP_XFER = 3'b010,
        SCDDP_DONE = 3'b100
    } scddp_state_t;

endpackage

// ---- scddp_rate_gen.sv ----
// serial clock rate generator: one tick per half period of the serial clock
`timescale 1ns/1ps
`default_nettype none

module scddp_rate_gen #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // control
    input  wire logic             runEn,
    input  wire logic [DIV_W-1:0] divVal,
    // half-period tick
    output logic                  tick
);

    // ==========================================================
    // counter
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;

    // >= keeps the counter from running past a divider lowered mid-frame
    assign tick    = runEn && (cnt_ff >= divVal);                 // [R1] [R3]
    assign nxt_cnt = (!runEn || tick) ? '0 : cnt_ff + 1'b1;       // [R4]

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // scddp_rate_gen

`default_nettype wire

// ---- scddp_core.sv ----
// serial port data register, clock divider register and byte shifter
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: as master the serial clock runs at the core clock divided by two times (divider value plus one).
// R2: the divider drives the serial clock only in master operation and has no effect as slave.
// R3: every divider value 0 to 255 is accepted, so the slowest clock is the core clock over 512.
// R4: the serial clock is made by counting core clock cycles and stays synchronous to it.
// R5: a data write while idle loads the shift register directly and, as master, starts a transfer at once.
// R6: a data read returns the last received byte and leaves the shift register untouched.
module scddp_core
    import scddp_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // special-function register port
    input  wire logic [7:0]        sfrAddr,
    input  wire logic              sfrWrEn,
    input  wire logic              sfrRdEn,
    input  wire logic [DATA_W-1:0] sfrWrData,
    output logic      [DATA_W-1:0] sfrRdData,
    // port control flags
    input  wire logic              masterEnable,
    input  wire logic              portEnable,
    output logic                   xferBusy,
    // serial clock pin
    input  wire logic              sckIn,
    output logic                   sckOut,
    output logic                   sckOe,
    // master-out pin
    input  wire logic              mosiIn,
    output logic                   mosiOut,
    output logic                   mosiOe,
    // master-in pin
    input  wire logic              misoIn,
    output logic                   misoOut,
    output logic                   misoOe,
    // slave select, active low
    input  wire logic              slaveSel_n
);

    // ==========================================================
    // registers
    scddp_state_t      state_ff;
    scddp_state_t      nxt_state;
    logic [7:0]        divider_ff;
    logic [DATA_W-1:0] shift_ff;
    logic [DATA_W-1:0] rxBuf_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic              sample_ff;
    logic [2:0]        bitCnt_ff;
    logic              sck_ff;
    logic              sckPrev_ff;
    logic              busy_ff;
    logic              sckOe_ff;
    logic              misoOe_ff;

    // ==========================================================
    // register decode
    wire wrData   = sfrWrEn && (sfrAddr == SCDDP_ADDR_DATA);
    wire wrDiv    = sfrWrEn && (sfrAddr == SCDDP_ADDR_DIV);
    wire rdData   = sfrRdEn && (sfrAddr == SCDDP_ADDR_DATA);
    wire rdDiv    = sfrRdEn && (sfrAddr == SCDDP_ADDR_DIV);
    wire isMaster = portEnable && masterEnable;
    wire isSlave  = portEnable && !masterEnable;

    // writes while a master frame runs are ignored; the collision flag lives elsewhere
    wire startXfer = wrData && isMaster && (state_ff == SCDDP_IDLE);     // [R5]
    wire loadShift = wrData && (state_ff == SCDDP_IDLE);                 // [R5]

    wire [DATA_W-1:0] nxt_rdData = rdData ? rxBuf_ff :                  // [R6]
                                   rdDiv  ? divider_ff : '0;

    // ==========================================================
    // edge events
    wire tick;
    wire runDiv = (state_ff == SCDDP_XFER) && isMaster;                  // [R2]
    wire mRise  = tick && !sck_ff;
    wire mFall  = tick && sck_ff;
    // slave pins are synchronous inputs, so a one-flop history gives the edges
    wire sActive = isSlave && !slaveSel_n;
    wire sRise   = sActive && sckIn && !sckPrev_ff;
    wire sFall   = sActive && !sckIn && sckPrev_ff;
    wire evRise  = mRise || sRise;
    wire evFall  = mFall || sFall;
    wire lastBit = evFall && (bitCnt_ff == SCDDP_LAST_BIT);
    wire bitIn   = isMaster ? misoIn : mosiIn;

    wire [DATA_W-1:0] shiftNext = {shift_ff[DATA_W-2:0], sample_ff};

    scddp_rate_gen #(
        .DIV_W (8)
    ) u_rate_gen (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .runEn   (runDiv),
        .divVal  (divider_ff),
        .tick    (tick)
    );

    // ==========================================================
    // transfer state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCDDP_IDLE: begin
                if (startXfer) begin
                    nxt_state = SCDDP_XFER;
                end
            end
            SCDDP_XFER: begin
                if (!isMaster) begin
                    nxt_state = SCDDP_IDLE;
                end else if (mFall && (bitCnt_ff == SCDDP_LAST_BIT)) begin
                    nxt_state = SCDDP_DONE;
                end
            end
            SCDDP_DONE: nxt_state = SCDDP_IDLE;
            default:    nxt_state = SCDDP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= SCDDP_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state == SCDDP_XFER);
        end
    end

    // ==========================================================
    // registers and shifter
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            divider_ff <= SCDDP_RST_DIV;
            rdData_ff  <= '0;
        end else begin
            if (wrDiv) begin
                divider_ff <= sfrWrData[7:0];                            // [R3]
            end
            rdData_ff <= nxt_rdData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shift_ff  <= SCDDP_RST_DATA;
            rxBuf_ff  <= SCDDP_RST_DATA;
            sample_ff <= 1'b0;
            bitCnt_ff <= '0;
        end else if (loadShift) begin
            shift_ff  <= sfrWrData;                                      // [R5]
            bitCnt_ff <= '0;
        end else if (evRise) begin
            sample_ff <= bitIn;
        end else if (evFall) begin
            shift_ff  <= shiftNext;
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (lastBit) begin
                rxBuf_ff <= shiftNext;
            end
        end else if (isSlave && slaveSel_n) begin
            bitCnt_ff <= '0;
        end
    end

    // ==========================================================
    // pins
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sck_ff     <= 1'b0;
            sckPrev_ff <= 1'b0;
            sckOe_ff   <= 1'b0;
            misoOe_ff  <= 1'b0;
        end else begin
            sckPrev_ff <= sckIn;
            sckOe_ff   <= isMaster;
            misoOe_ff  <= sActive;
            if (!runDiv) begin
                sck_ff <= 1'b0;
            end else if (tick) begin
                sck_ff <= !sck_ff;                                       // [R1] [R4]
            end
        end
    end

    assign sfrRdData = rdData_ff;
    assign xferBusy  = busy_ff;
    assign sckOut    = sck_ff;
    assign sckOe     = sckOe_ff;
    assign mosiOut   = shift_ff[DATA_W-1];
    assign mosiOe    = sckOe_ff;
    assign misoOut   = shift_ff[DATA_W-1];
    assign misoOe    = misoOe_ff;

    // ==========================================================
    // checks
    logic [8:0] halfCnt_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !runDiv || tick) begin
            halfCnt_ff <= '0;
        end else begin
            halfCnt_ff <= halfCnt_ff + 9'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_half_period_len: assert property (tick && $stable(divider_ff) |-> halfCnt_ff == {1'b0, divider_ff}) // [R1]
        else $error("serial clock half period does not match divider");
    a_div_slave_quiet: assert property (!isMaster |=> !sck_ff && !tick) // [R2]
        else $error("serial clock toggles outside master operation");
    a_div_range_max: assert property (tick |-> halfCnt_ff <= SCDDP_DIV_MAX) // [R3]
        else $error("half period longer than 256 core cycles");
    a_sck_sync_edge: assert property ($changed(sck_ff) && runDiv |-> $past(tick)) // [R4]
        else $error("serial clock changed without a divider tick");
    a_write_starts: assert property (startXfer |=> busy_ff && state_ff == SCDDP_XFER // [R5]
                                                && shift_ff == $past(sfrWrData))
        else $error("data write did not start a transfer");
    a_read_returns: assert property (rdData |=> sfrRdData == $past(rxBuf_ff)) // [R6]
        else $error("data read did not return the receive buffer");
    a_read_no_touch: assert property (rdData && !sfrWrEn && state_ff == SCDDP_IDLE && !sActive // [R6]
                                      |=> $stable(shift_ff))
        else $error("data read disturbed the shift register");
    a_frame_ends: assert property (state_ff == SCDDP_DONE |-> !busy_ff ##1 state_ff == SCDDP_IDLE) // [R5]
        else $error("transfer end sequence broken");

    c_master_frame: cover property (startXfer ##[1:600] state_ff == SCDDP_DONE);
    c_slave_byte:   cover property (sActive && lastBit);
    c_slow_divider: cover property (tick && divider_ff == 8'hFF);

endmodule // scddp_core

`default_nettype wire

// ---- scddp_slave_model.sv ----
// partner model: external serial slave on the master link
`timescale 1ns/1ps
`default_nettype none

module scddp_slave_model (
    // link pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel,
    output logic            miso,
    // bench side
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    output logic      [7:0] rxByte
);
    logic [7:0] shiftReg = 8'h00;
    logic       lastBit  = 1'b0;
    initial rxByte = 8'h00;
    always @(posedge load) shiftReg = txByte;
    // mode 0: sample on rise, shift on fall, msb first
    always @(posedge sck) if (sel) rxByte = {rxByte[6:0], mosi};
    always @(negedge sck) if (sel) shiftReg = {shiftReg[6:0], 1'b0};
    always @(negedge sel) lastBit = shiftReg[7];
    // released line shows the inverse, so a stale bit cannot pass for data
    assign miso = sel ? shiftReg[7] : ~lastBit;
endmodule // scddp_slave_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the serial clock divider and data port
`timescale 1ns/1ps
`default_nettype none

module tb;
    import scddp_pkg::*;
    typedef struct {logic [7:0] d, tx, rx;} scddp_row_t;
    logic       clk_sys, sys_rst, sfrWrEn, sfrRdEn, masterEnable, portEnable;
    logic       sckIn, mosiIn, slaveSel_n, load;
    logic [7:0] sfrAddr, sfrWrData, slvTx;
    wire logic [7:0] sfrRdData, slvRx;
    wire logic  xferBusy, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, misoIn;
    int         errors, compares, n, rises;
    scddp_row_t rows [4] = '{'{8'h00, 8'hA5, 8'h3C}, '{8'h01, 8'h5A, 8'hC3},
                             '{8'h04, 8'h80, 8'h01}, '{8'hFF, 8'h01, 8'h80}};

    scddp_core u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .masterEnable(masterEnable), .portEnable(portEnable), .xferBusy(xferBusy),
        .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut),
        .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe),
        .slaveSel_n(slaveSel_n));
    scddp_slave_model u_slave (.sck(sckOut), .mosi(mosiOut), .sel(xferBusy), .miso(misoIn),
        .load(load), .txByte(slvTx), .rxByte(slvRx));

    // ==========================================================
    // clock, monitor, tasks
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge sckOut) rises++;
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        step();
        sfrWrEn = 1'b0;
        step();
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        step();
        chk({8'h00, sfrRdData}, {8'h00, exp}, "read data");
        sfrRdEn = 1'b0;
        step();
    endtask
    task automatic waitIdle();
        n = 1;
        while (xferBusy === 1'b1 && n < 5000) begin
            n++;
            step();
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        give_verdict();
    end

    // ==========================================================
    // tests
    initial begin
        {sys_rst, sfrWrEn, sfrRdEn, sckIn, mosiIn, load} = 6'h20;
        {masterEnable, portEnable, slaveSel_n} = 3'h7;
        {sfrAddr, sfrWrData, slvTx} = 24'h0;
        repeat (8) step();
        sys_rst = 1'b0;
        rd(SCDDP_ADDR_DATA, SCDDP_RST_DATA);
        rd(SCDDP_ADDR_DIV, SCDDP_RST_DIV);
        rd(8'h9C, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(SCDDP_ADDR_DIV, rows[i].d);
            slvTx = rows[i].rx;
            load = 1'b1;
            rises = 0;
            wr(SCDDP_ADDR_DATA, rows[i].tx);
            load = 1'b0;
            waitIdle();
            chk(16'(n), 16'(16 * (rows[i].d + 1)), "frame length");
            chk({14'h0, sckOe, mosiOe}, 16'h0003, "master pins");
            chk(16'(rises), 16'h0008, "clock rises");
            chk({8'h00, slvRx}, {8'h00, rows[i].tx}, "sent byte");
            rd(SCDDP_ADDR_DATA, rows[i].rx);
            rd(SCDDP_ADDR_DIV, rows[i].d);
            $display("test row %0d done", i);
        end
        // a write during a running frame is dropped
        wr(SCDDP_ADDR_DIV, 8'h03);
        slvTx = 8'h80;
        load = 1'b1;
        wr(SCDDP_ADDR_DATA, 8'h81);
        load = 1'b0;
        wr(SCDDP_ADDR_DATA, 8'hFF);
        waitIdle();
        chk({8'h00, slvRx}, 16'h0081, "busy write");
        $display("test busy write done");
        // slave: divider is ignored, bench clocks at a half period of 3
        masterEnable = 1'b0;
        wr(SCDDP_ADDR_DIV, 8'hFF);
        wr(SCDDP_ADDR_DATA, 8'hC3);
        chk({15'h0, xferBusy | sckOe}, 16'h0000, "slave start");
        rd(SCDDP_ADDR_DATA, 8'h80);
        chk({15'h0, misoOut}, 16'h0001, "shift kept");
        slaveSel_n = 1'b0;
        step();
        chk({14'h0, misoOe, mosiOe}, 16'h0002, "slave pins");
        for (int b = 7; b >= 0; b--) begin
            chk(16'(misoOut), 16'(8'hC3 >> b) & 16'h0001, "slave out bit");
            mosiIn = b[0];
            sckIn = 1'b1;
            repeat (3) step();
            sckIn = 1'b0;
            repeat (3) step();
        end
        mosiIn = ~mosiIn;
        slaveSel_n = 1'b1;
        repeat (2) step();
        rd(SCDDP_ADDR_DATA, 8'hAA);
        $display("test slave done");
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        rd(SCDDP_ADDR_DIV, SCDDP_RST_DIV);
        $display("test second reset done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
